/* File: common/clkctl_defs.vh */
// constants for the differential clock output stop and power-down control
`ifndef CLKCTL_DEFS_VH
`define CLKCTL_DEFS_VH

// register byte offsets
`define OFS_CONTROL       3'h0
`define OFS_OUT_ENABLE    3'h1
`define OFS_STOPPABLE     3'h2
`define OFS_RESERVED      3'h3
`define OFS_VENDOR_REV    3'h4
`define OFS_PART_ID       3'h5
`define OFS_BYTE_COUNT    3'h6

// control byte fields
`define BIT_PD_DRIVE      7
`define BIT_STOP_DRIVE    6

// reset values
`define RST_CONTROL       8'h05
`define RST_OUT_ENABLE    8'hff
`define RST_STOPPABLE     8'h00
`define RST_BYTE_COUNT    8'h07

// timing
`define CLK_MHZ           100
`define LOCK_TIME_US      1000
`define LOCK_CYCLES       (`LOCK_TIME_US * `CLK_MHZ - 64)
`define HALF_PERIOD       4

`endif

/* File: rtl/level_qualifier.v */
// samples an asynchronous level on output-clock ticks and accepts it once stable
module level_qualifier
(
  // clock and reset
  input  wire clk,
  input  wire nrst,
  // sampling
  input  wire tick,
  input  wire din,
  // qualified level
  output reg  level
);

  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end
    else if (tick)
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end

endmodule // level_qualifier

/* File: rtl/control_bytes.v */
// control byte registers with registered read data
`include "clkctl_defs.vh"

module control_bytes
#(
  parameter [7:0] VENDOR_REV = 8'h3c, // arbitrary value
  parameter [7:0] PART_ID    = 8'h5a  // arbitrary value
)
(
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // access port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // fields
  output reg  [7:0] control,
  output reg  [7:0] out_enable,
  output reg  [7:0] stoppable,
  output reg  [7:0] byte_count
);

  reg [7:0] part_identifier;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      control         <= `RST_CONTROL;
      out_enable      <= `RST_OUT_ENABLE;
      stoppable       <= `RST_STOPPABLE;   // R16
      byte_count      <= `RST_BYTE_COUNT;  // R15
      part_identifier <= PART_ID;
      reg_rdata       <= 8'h00;
    end
    else
    begin
      if (reg_write)
      begin
        case (reg_addr)
          `OFS_CONTROL:    control <= reg_wdata;
          `OFS_OUT_ENABLE: out_enable <= reg_wdata;
          `OFS_STOPPABLE:  stoppable <= reg_wdata;
          `OFS_PART_ID:    part_identifier <= reg_wdata;
          `OFS_BYTE_COUNT: byte_count <= reg_wdata; // R15
          default:         ;
        endcase
      end
      if (reg_read)
      begin
        case (reg_addr)
          `OFS_CONTROL:    reg_rdata <= control;
          `OFS_OUT_ENABLE: reg_rdata <= out_enable;
          `OFS_STOPPABLE:  reg_rdata <= stoppable;
          `OFS_VENDOR_REV: reg_rdata <= VENDOR_REV;
          `OFS_PART_ID:    reg_rdata <= part_identifier;
          `OFS_BYTE_COUNT: reg_rdata <= byte_count;
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // control_bytes

/* File: rtl/clock_output_stop_powerdown.v */
// output stop and power-down control of an eight-output differential buffer
//
// Contract
// R01 - two low samples park outputs next edge
// R02 - powerdown driven mode: true high, complement floats
// R03 - powerdown float mode: both legs float
// R04 - powerdown async low; park before pll stops
// R05 - host asserts powerdown before removing clock
// R06 - locked clocks within 1 ms of release
// R07 - float mode: drive outputs soon after release
// R08 - stop input accepted after two stable samples
// R09 - host keeps reference clock when using stop
// R10 - stoppable outputs halt after next transition
// R11 - stop driven mode: true high, complement floats
// R12 - stop float mode: both legs float
// R13 - restart together, 2 to 6 periods later
// R14 - float mode: drive high within 10 ns
// R15 - byte count register, resets to seven
// R16 - per-output stoppable bit, resets free-run
// R17 - toggle only if register and pin enable
// R18 - two-stage synchroniser on complement clock
`include "clkctl_defs.vh"

module clock_output_stop_powerdown
#(
  parameter        LANES       = 8,
  parameter        HALF_PERIOD = `HALF_PERIOD,
  parameter [31:0] LOCK_CYCLES = `LOCK_CYCLES
)
(
  // clock and reset
  input  wire             clk,
  input  wire             nrst,
  // control pins
  input  wire             power_down_n,
  input  wire             output_halt_n,
  input  wire [LANES-1:0] enable_pin,
  input  wire             enable_polarity_invert,
  // register port
  input  wire [2:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_write,
  input  wire             reg_read,
  output wire [7:0]       reg_rdata,
  output reg  [7:0]       readback_length,
  // clock outputs
  output reg  [LANES-1:0] clock_out_true,
  output reg  [LANES-1:0] clock_out_true_oe,
  output reg  [LANES-1:0] clock_out_complement,
  output reg  [LANES-1:0] clock_out_complement_oe,
  output reg              bias_six_times,
  // status
  output reg              pll_run,
  output reg              pll_locked
);

  localparam [1:0] ST_LOCK   = 2'd0;
  localparam [1:0] ST_RUN    = 2'd1;
  localparam [1:0] ST_PARKED = 2'd2;

  wire [7:0] control;
  wire [7:0] out_enable;
  wire [7:0] stoppable;
  wire [7:0] byte_count;
  wire       pd_level;
  wire       halt_level;

  reg  [15:0]      div_cnt;
  reg              phase;
  reg  [1:0]       state;
  reg  [31:0]      lock_cnt;
  reg  [LANES-1:0] stopped;
  reg  [LANES-1:0] next_true;
  reg  [LANES-1:0] next_true_oe;
  reg  [LANES-1:0] next_comp;
  reg  [LANES-1:0] next_comp_oe;
  reg              next_bias;
  integer          i;

  wire phase_en  = (div_cnt == HALF_PERIOD[15:0] - 16'h0001);
  wire comp_rise = phase_en & ~phase;
  wire true_rise = phase_en & phase;
  wire pd_drive_float   = control[`BIT_PD_DRIVE];
  wire stop_drive_float = control[`BIT_STOP_DRIVE];
  wire [LANES-1:0] pin_active = enable_polarity_invert ? enable_pin : ~enable_pin;
  wire [LANES-1:0] lane_enabled = out_enable[LANES-1:0] & pin_active;

  control_bytes regs
  (
    .clk        (clk),
    .nrst       (nrst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_write  (reg_write),
    .reg_read   (reg_read),
    .reg_rdata  (reg_rdata),
    .control    (control),
    .out_enable (out_enable),
    .stoppable  (stoppable),
    .byte_count (byte_count)
  );

  // power-down and stop sampled on complement rising ticks
  level_qualifier pd_sync // R18
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (comp_rise),
    .din   (power_down_n),
    .level (pd_level)
  );

  level_qualifier halt_sync // R18
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (comp_rise),
    .din   (output_halt_n),
    .level (halt_level)
  );

  // output clock divider, keeps ticking while parked
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt <= 16'h0000;
      phase   <= 1'b0;
    end
    else if (phase_en)
    begin
      div_cnt <= 16'h0000;
      phase   <= ~phase;
    end
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // power-down sequencing
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state      <= ST_LOCK;
      lock_cnt   <= 32'h0;
      pll_run    <= 1'b1;
      pll_locked <= 1'b0;
    end
    else
    begin
      case (state)
        ST_LOCK:
        begin
          if (lock_cnt < LOCK_CYCLES)
            lock_cnt <= lock_cnt + 32'h1;
          else if (true_rise)
          begin
            state      <= ST_RUN;
            pll_locked <= 1'b1; // R06
          end
        end
        ST_RUN:
        begin
          if (!pd_level && true_rise) // R01
          begin
            state      <= ST_PARKED;
            pll_locked <= 1'b0;
          end
        end
        ST_PARKED:
        begin
          pll_run <= 1'b0; // R04
          if (pd_level) // R04
          begin
            state    <= ST_LOCK;
            lock_cnt <= 32'h0;
            pll_run  <= 1'b1;
          end
        end
        default:
          state <= ST_LOCK;
      endcase
    end
  end

  // stop and restart on the true rising edge so lanes stay glitch-free
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stopped <= {LANES{1'b0}};
    else if (true_rise)
    begin
      if (!halt_level) // R08
        stopped <= stopped | (stoppable[LANES-1:0] & lane_enabled); // R10
      else
        stopped <= {LANES{1'b0}}; // R13
    end
  end

  // lane drive
  always @*
  begin
    next_bias = 1'b1;
    for (i = 0; i < LANES; i = i + 1)
    begin
      next_true[i]    = 1'b0;
      next_true_oe[i] = 1'b1;
      next_comp[i]    = 1'b1;
      next_comp_oe[i] = 1'b1;
      if (state == ST_PARKED)
      begin
        next_true[i]    = 1'b1;
        next_true_oe[i] = ~pd_drive_float; // R02 R03
        next_comp[i]    = 1'b0;
        next_comp_oe[i] = 1'b0;
        next_bias       = 1'b0; // R02
      end
      else if (state == ST_LOCK)
      begin
        next_true[i] = 1'b1; // R07
        next_comp[i] = 1'b0;
      end
      else if (stopped[i])
      begin
        next_true[i]    = 1'b1;
        next_true_oe[i] = ~stop_drive_float | output_halt_n; // R11 R12 R14
        next_comp[i]    = 1'b0;
        next_comp_oe[i] = 1'b0; // R11
      end
      else if (lane_enabled[i]) // R17
      begin
        next_true[i] = ~phase ^ phase_en;
        next_comp[i] = phase ^ phase_en;
      end
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_out_true          <= {LANES{1'b0}};
      clock_out_true_oe       <= {LANES{1'b0}};
      clock_out_complement    <= {LANES{1'b0}};
      clock_out_complement_oe <= {LANES{1'b0}};
      bias_six_times          <= 1'b1;
      readback_length         <= `RST_BYTE_COUNT;
    end
    else
    begin
      clock_out_true          <= next_true;
      clock_out_true_oe       <= next_true_oe;
      clock_out_complement    <= next_comp;
      clock_out_complement_oe <= next_comp_oe;
      bias_six_times          <= next_bias;
      readback_length         <= byte_count; // R15
    end
  end

endmodule // clock_output_stop_powerdown

/* File: bench/clock_receiver.sv */
// downstream receiver model: terminated true leg of one lane and its rising edges
module clock_receiver
(
  // clock
  input  wire        clk,
  // observed lane
  input  wire        true_leg,
  input  wire        true_oe,
  // results
  output logic [15:0] edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_seen = 1'b0;
  logic last_oe   = 1'b0;
  wire  seen      = true_leg & true_oe;
  initial edges = 16'h0000;
  // an edge counts only while the leg was already driven
  always @(posedge clk)
  begin
    if (seen && !last_seen && last_oe)
      edges <= edges + 16'h0001;
    last_seen <= seen;
    last_oe   <= true_oe;
  end
endmodule // clock_receiver

/* File: bench/clock_output_stop_powerdown_checker.sv */
// port assertions for the output stop and power-down control
module clock_output_stop_powerdown_checker
#(
  parameter        LANES       = 8,
  parameter        HALF_PERIOD = 4,
  parameter [31:0] LOCK_CYCLES = 20
)
(
  // clock and reset
  input wire             clk,
  input wire             nrst,
  // pins
  input wire             power_down_n,
  input wire [LANES-1:0] enable_pin,
  input wire             enable_polarity_invert,
  input wire [2:0]       reg_addr,
  input wire [7:0]       reg_wdata,
  input wire             reg_write,
  // outputs
  input wire [7:0]       readback_length,
  input wire [LANES-1:0] clock_out_true,
  input wire [LANES-1:0] clock_out_complement_oe,
  input wire             bias_six_times,
  input wire             pll_run,
  input wire             pll_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int lock_max = LOCK_CYCLES + 2 * HALF_PERIOD + 16;
  wire on0  = enable_pin[0] == enable_polarity_invert;
  wire off1 = enable_pin[1] != enable_polarity_invert;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  lock_time_a: assert property ($rose(pll_run) |-> ##[0:lock_max] pll_locked)
    else $error("lock late");
  park_unlock_a: assert property (!pll_run |-> !pll_locked)
    else $error("locked while parked");
  park_float_a: assert property (!pll_run && !$past(pll_run) |-> clock_out_complement_oe == '0)
    else $error("complement driven in power-down");
  bias_run_a: assert property (pll_locked |-> bias_six_times)
    else $error("bias changed while running");
  pd_qualify_a: assert property ($fell(pll_run) |-> $past(power_down_n, 8) == 1'b0)
    else $error("park without qualified request");
  lane_off_a: assert property ((off1 && pll_locked)[*8] |=> $stable(clock_out_true[1]))
    else $error("disabled lane toggled");
  free_run_a: assert property ((on0 && pll_locked)[*8] ##1 (on0 && pll_locked)[*4]
    |-> clock_out_true[0] != $past(clock_out_true[0], HALF_PERIOD)) else $error("lane stalled");
  count_copy_a: assert property (reg_write && reg_addr == 3'h6
    |-> ##3 readback_length == $past(reg_wdata, 3)) else $error("length not updated");
  cover property ($fell(pll_run));
  cover property ($rose(pll_locked));
  cover property (off1 && pll_locked);
endmodule // clock_output_stop_powerdown_checker

bind clock_output_stop_powerdown clock_output_stop_powerdown_checker
  #(.LANES(LANES), .HALF_PERIOD(HALF_PERIOD), .LOCK_CYCLES(LOCK_CYCLES)) chk_u
  (.clk(clk), .nrst(nrst), .power_down_n(power_down_n), .enable_pin(enable_pin),
   .enable_polarity_invert(enable_polarity_invert), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .readback_length(readback_length),
   .clock_out_true(clock_out_true), .clock_out_complement_oe(clock_out_complement_oe),
   .bias_six_times(bias_six_times), .pll_run(pll_run), .pll_locked(pll_locked));

/* File: bench/tb_clock_output_stop_powerdown.sv */
// testbench for the output stop and power-down control
module tb_clock_output_stop_powerdown;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, nrst = 0, pd_n = 1, halt_n = 1, inv = 0, we = 0, re = 0;
  logic [7:0]  pins = 8'h00, wd = 8'h00, rdata, rlen, t, toe, c, coe, got;
  logic [2:0]  ad = 3'h0;
  logic        bias, run, lock;
  logic [15:0] edges, e0;
  int          failures = 0, total_checks = 0, i, n;
  // register address beside expected reset value
  logic [10:0] rows [8] = '{11'h005, 11'h1ff, 11'h200, 11'h300,
                            11'h43c, 11'h55a, 11'h607, 11'h700};
  always #5 clk = ~clk;
  clock_output_stop_powerdown #(.LOCK_CYCLES(20)) dut_u
  (.clk(clk), .nrst(nrst), .power_down_n(pd_n), .output_halt_n(halt_n), .enable_pin(pins),
   .enable_polarity_invert(inv), .reg_addr(ad), .reg_wdata(wd), .reg_write(we),
   .reg_read(re), .reg_rdata(rdata), .readback_length(rlen), .clock_out_true(t),
   .clock_out_true_oe(toe), .clock_out_complement(c), .clock_out_complement_oe(coe),
   .bias_six_times(bias), .pll_run(run), .pll_locked(lock));
  clock_receiver rx_u (.clk(clk), .true_leg(t[7]), .true_oe(toe[7]), .edges(edges));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    ad = a;
    wd = d;
    we = w;
    re = !w;
    @(negedge clk);
    we = 0;
    re = 0;
    @(negedge clk);
    got = rdata;
  endtask
  task automatic lk;
    for (i = 0; i < 300 && lock !== 1'b1; i++)
      @(negedge clk);
    chk({7'h00, lock}, 8'h01);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #50us;
    failures++;
    report_and_stop;
  end
  initial
  begin
    repeat (2) @(negedge clk);
    nrst = 1;
    for (int k = 0; k < 8; k++)
    begin
      acc(0, rows[k][10:8], 8'h00);
      chk(got, rows[k][7:0]);
    end
    acc(1, 3'h6, 8'h1f);
    acc(0, 3'h6, 8'h00);
    chk(got, 8'h1f);
    chk(rlen, 8'h1f);
    $display("test registers done");
    acc(1, 3'h2, 8'h80);
    lk;
    for (int m = 0; m < 2; m++)
    begin
      acc(1, 3'h0, {1'b0, m[0], 6'h05});
      halt_n = 0;
      repeat (40) @(negedge clk);
      chk({4'h0, toe[7], coe[7], t[7], bias}, m ? 8'h03 : 8'h0b);
      e0 = edges;
      repeat (16) @(negedge clk);
      chk(edges[7:0], e0[7:0]);
      halt_n = 1;
      for (n = 0; n < 1 && toe[7] !== 1'b1; n++)
        @(negedge clk);
      chk(toe & 8'h80, 8'h80);
      for (; n < 70 && edges == e0; n++)
        @(negedge clk);
      chk(8'(n >= 16 && n <= 53), 8'h01);
    end
    $display("test stop done");
    for (int m = 0; m < 2; m++)
    begin
      acc(1, 3'h0, {m[0], 7'h05});
      pd_n = 0;
      repeat (40) @(negedge clk);
      chk(t & toe, m ? 8'h00 : 8'hff);
      chk(coe | {run, bias, 6'h00}, 8'h00);
      pd_n = 1;
      for (n = 0; n < 40 && toe !== 8'hff; n++)
        @(negedge clk);
      chk(toe, 8'hff);
      lk;
    end
    $display("test power-down done");
    pins = 8'h82;
    @(negedge clk);
    e0 = edges;
    repeat (24) @(negedge clk);
    chk(t & 8'h82, 8'h00);
    chk(c & 8'h82, 8'h82);
    chk(edges[7:0], e0[7:0]);
    inv = 1;
    pins = 8'hfd;
    e0 = edges;
    repeat (24) @(negedge clk);
    chk(t & 8'h02, 8'h00);
    chk(t ^ c, 8'hff);
    chk(8'((edges - e0) >= 16'h0002), 8'h01);
    $display("test enable done");
    nrst = 0;
    @(negedge clk);
    chk(rlen, 8'h07);
    nrst = 1;
    acc(0, 3'h2, 8'h00);
    chk(got, 8'h00);
    $display("test reset done");
    report_and_stop;
  end
endmodule // tb_clock_output_stop_powerdown
